/* File: inc/sbm_regs.svh */
// Register offsets, field positions, reset values and fixed counts of the
// shunt and bus monitor alert block.
// Assumes a 32-bit APB with byte addresses; data sits in the low bits.
`ifndef SBM_REGS_SVH
`define SBM_REGS_SVH

// Register byte offsets
`define SBM_OFF_CONFIG   8'h00
`define SBM_OFF_MASK_EN  8'h04
`define SBM_OFF_CRIT1    8'h08
`define SBM_OFF_WARN1    8'h14
`define SBM_OFF_SUM_LIM  8'h20
`define SBM_OFF_PV_UP    8'h24
`define SBM_OFF_PV_LO    8'h28
`define SBM_OFF_SHUNT1   8'h2c
`define SBM_OFF_BUS1     8'h38
`define SBM_OFF_SUM      8'h44

// Configuration fields
`define SBM_CFG_MODE_LSB 0
`define SBM_CFG_AVG_LSB  3
`define SBM_CFG_CHEN_LSB 6

// Mask and enable fields
`define SBM_ME_CF_LSB    0
`define SBM_ME_SF_BIT    3
`define SBM_ME_WF_LSB    4
`define SBM_ME_PV_BIT    7
`define SBM_ME_CONVERSION_READY_FLAG_BIT  8
`define SBM_ME_SCC_LSB   12

// Reset values
`define SBM_MODE_RST     3'h7
`define SBM_AVG_RST      3'h0
`define SBM_CHEN_RST     3'h7
`define SBM_SCC_RST      3'h0
`define SBM_LIM_MAX      16'h0fff
`define SBM_SUM_LIM_RST  16'h7fff
`define SBM_BUS_LSB_MV   8
`define SBM_PV_UP_MV     10000
`define SBM_PV_LO_MV     9000
`define SBM_PV_UP_RST    (16'(`SBM_PV_UP_MV / `SBM_BUS_LSB_MV))
`define SBM_PV_LO_RST    (16'(`SBM_PV_LO_MV / `SBM_BUS_LSB_MV))

// Converter word and pass layout
`define SBM_ADC_BITS     13
`define SBM_LAST_SLOT    3'h5

`endif

/* File: inc/sbm_pkg.sv */
// Types shared by the shunt and bus monitor alert block.
// Assumes sbm_regs.svh supplies the numeric constants.
package sbm_pkg;

	typedef logic signed [15:0] sbm_word_t;

	typedef enum logic [1:0] {
		SBM_IDLE = 2'b00,
		SBM_PICK = 2'b01,
		SBM_WAIT = 2'b10
	} sbm_seq_t;

endpackage

/* File: logic/sbm_monitor.sv */
// Conversion sequencer, averaging and alert logic of a three-channel shunt
// and bus voltage monitor, with an APB register slave.
// Assumes an external converter that returns each result serially on a
// free clock pin (sampled here) and open-drain alert pads outside.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "sbm_regs.svh"

module sbm_monitor (
	input  wire logic               clk_sys,     // 25 MHz clock
	input  wire logic               srst,        // Sync reset, high
	input  wire logic               psel,        // APB select
	input  wire logic               penable,     // APB access phase
	input  wire logic               pwrite,      // APB write
	input  wire logic [7:0]         paddr,       // APB byte address
	input  wire logic [31:0]        pwdata,      // APB write data
	output logic      [31:0]        prdata,      // APB read data
	output logic                    pready,      // APB ready
	output logic                    pslverr,     // APB error
	output logic                    conv_req,    // Start one conversion
	output logic      [2:0]         conv_sel,    // Channel and kind
	input  wire logic               adc_sclk,    // Result bit clock pin
	input  wire logic               adc_sdata,   // Result data pin
	input  wire logic               adc_frame,   // Result frame pin
	output logic                    crit_o,      // Critical pad out
	output logic                    crit_oe,     // Critical pad enable
	output logic                    warn_o,      // Warning pad out
	output logic                    warn_oe,     // Warning pad enable
	output logic                    power_good_output_o,  // Pad out
	output logic                    power_good_output_oe, // Pad enable
	output logic                    sequence_timing_output_o,  // Pad out
	output logic                    sequence_timing_output_oe  // Pad enable
);
	import sbm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [3:0] avg_shift(input logic [2:0] code);
		case (code)
			3'h0: avg_shift = 4'h0;
			3'h1: avg_shift = 4'h2;
			3'h2: avg_shift = 4'h4;
			3'h3: avg_shift = 4'h6;
			3'h4: avg_shift = 4'h7;
			3'h5: avg_shift = 4'h8;
			3'h6: avg_shift = 4'h9;
			default: avg_shift = 4'ha;
		endcase
	endfunction

	function automatic logic slot_wanted(input logic [2:0] slot,
			input logic [2:0] mode, input logic [2:0] chen);
		slot_wanted = chen[slot[2:1]] && (slot[0] ? mode[1] : mode[0]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers and state

	logic [2:0]  mode_q, avg_q, chen_q, scc_q;
	sbm_word_t   crit_lim_q [3];
	sbm_word_t   warn_lim_q [3];
	sbm_word_t   shunt_raw_q [3];
	sbm_word_t   shunt_avg_q [3];
	sbm_word_t   bus_q [3];
	sbm_word_t   sum_lim_q, pv_up_q, pv_lo_q, sum_q;
	logic [2:0]  cf_q, wf_q;
	logic        sf_q, pv_good_q, conversion_ready_flag_q, run_q;
	sbm_seq_t    seq_q;
	logic [2:0]  slot_q;
	logic        pass_end;
	logic [2:0]  sclk_s, frame_s;
	logic [1:0]  sdat_s;
	logic [15:0] shift_q;
	logic        word_done, res_stb;
	sbm_word_t   res_val, sum_d;
	logic        eval_q;
	logic [2:0]  eval_slot_q;
	logic        sum_en;
	logic [31:0] rdata_d;
	logic        unmapped;
	logic        wr_done, rd_setup, cfg_wr, mask_rd;

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait-free access, answer registered in setup

	assign wr_done = psel && penable && pready && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign cfg_wr  = wr_done && paddr == `SBM_OFF_CONFIG;
	// Clear at capture, so a flag set after capture is never lost
	assign mask_rd = rd_setup && paddr == `SBM_OFF_MASK_EN;

	always_comb begin
		rdata_d  = 32'h0;
		unmapped = 1'b0;
		case (paddr)
			`SBM_OFF_CONFIG: rdata_d[8:0] = {chen_q, avg_q, mode_q};
			`SBM_OFF_MASK_EN: rdata_d[14:0] = {scc_q, 3'h0, conversion_ready_flag_q,
				pv_good_q, wf_q, sf_q, cf_q};
			8'h08: rdata_d[15:0] = crit_lim_q[0];
			8'h0c: rdata_d[15:0] = crit_lim_q[1];
			8'h10: rdata_d[15:0] = crit_lim_q[2];
			8'h14: rdata_d[15:0] = warn_lim_q[0];
			8'h18: rdata_d[15:0] = warn_lim_q[1];
			8'h1c: rdata_d[15:0] = warn_lim_q[2];
			`SBM_OFF_SUM_LIM: rdata_d[15:0] = sum_lim_q;
			`SBM_OFF_PV_UP: rdata_d[15:0] = pv_up_q;
			`SBM_OFF_PV_LO: rdata_d[15:0] = pv_lo_q;
			8'h2c: rdata_d[15:0] = shunt_avg_q[0];
			8'h30: rdata_d[15:0] = shunt_avg_q[1];
			8'h34: rdata_d[15:0] = shunt_avg_q[2];
			8'h38: rdata_d[15:0] = bus_q[0];
			8'h3c: rdata_d[15:0] = bus_q[1];
			8'h40: rdata_d[15:0] = bus_q[2];
			`SBM_OFF_SUM: rdata_d[15:0] = sum_q;
			default: unmapped = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && unmapped;
			if (psel && !penable)
				prdata <= pwrite ? 32'h0 : rdata_d;
		end
	end

	// Limits and selects; new values apply to the next comparison
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_q    <= `SBM_MODE_RST;
			avg_q     <= `SBM_AVG_RST;
			chen_q    <= `SBM_CHEN_RST;
			scc_q     <= `SBM_SCC_RST;
			sum_lim_q <= `SBM_SUM_LIM_RST;
			pv_up_q   <= `SBM_PV_UP_RST;
			pv_lo_q   <= `SBM_PV_LO_RST;
			for (int i = 0; i < 3; i++) begin
				crit_lim_q[i] <= `SBM_LIM_MAX;
				warn_lim_q[i] <= `SBM_LIM_MAX;
			end
		end else if (wr_done) begin
			case (paddr)
				`SBM_OFF_CONFIG: begin
					mode_q <= pwdata[`SBM_CFG_MODE_LSB +: 3];
					avg_q  <= pwdata[`SBM_CFG_AVG_LSB +: 3];
					chen_q <= pwdata[`SBM_CFG_CHEN_LSB +: 3];
				end
				`SBM_OFF_MASK_EN: scc_q <= pwdata[`SBM_ME_SCC_LSB +: 3];
				8'h08: crit_lim_q[0] <= pwdata[15:0];
				8'h0c: crit_lim_q[1] <= pwdata[15:0];
				8'h10: crit_lim_q[2] <= pwdata[15:0];
				8'h14: warn_lim_q[0] <= pwdata[15:0];
				8'h18: warn_lim_q[1] <= pwdata[15:0];
				8'h1c: warn_lim_q[2] <= pwdata[15:0];
				`SBM_OFF_SUM_LIM: sum_lim_q <= pwdata[15:0];
				`SBM_OFF_PV_UP: pv_up_q <= pwdata[15:0];
				`SBM_OFF_PV_LO: pv_lo_q <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Converter result port: pins pass two flops, third stage finds edges

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sclk_s  <= 3'h0;
			sdat_s  <= 2'h0;
			frame_s <= 3'h0;
		end else begin
			sclk_s  <= {sclk_s[1:0], adc_sclk};
			sdat_s  <= {sdat_s[0], adc_sdata};
			frame_s <= {frame_s[1:0], adc_frame};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			shift_q <= 16'h0;
		else if (frame_s[1] && sclk_s[1] && !sclk_s[2])
			shift_q <= {shift_q[14:0], sdat_s[1]};
	end

	assign word_done = frame_s[2] && !frame_s[1];
	assign res_stb   = word_done && seq_q == SBM_WAIT;
	assign res_val   = sbm_word_t'({{(16 - `SBM_ADC_BITS)
		{shift_q[`SBM_ADC_BITS - 1]}}, shift_q[`SBM_ADC_BITS - 1:0]});

	////////////////////////////////////////////////////////////////////////
	// Sequencer: slots shunt1, bus1, shunt2, bus2, shunt3, bus3

	assign pass_end = slot_q == `SBM_LAST_SLOT && ((seq_q == SBM_PICK &&
		!slot_wanted(slot_q, mode_q, chen_q)) || res_stb);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			seq_q    <= SBM_PICK;
			run_q    <= 1'b1;
			slot_q   <= 3'h0;
			conv_req <= 1'b0;
			conv_sel <= 3'h0;
		end else begin
			conv_req <= 1'b0;
			if (cfg_wr) begin
				// Any mode write restarts the pass; power-down stops it
				run_q  <= pwdata[1:0] != 2'h0;
				seq_q  <= pwdata[1:0] != 2'h0 ? SBM_PICK : SBM_IDLE;
				slot_q <= 3'h0;
			end else begin
				case (seq_q)
					SBM_IDLE: slot_q <= 3'h0;
					SBM_PICK: begin
						if (slot_wanted(slot_q, mode_q, chen_q)) begin
							conv_req <= 1'b1;
							conv_sel <= slot_q;
							seq_q    <= SBM_WAIT;
						end else if (!pass_end) begin
							slot_q <= slot_q + 3'h1;
						end
					end
					SBM_WAIT: begin
						if (res_stb && !pass_end) begin
							slot_q <= slot_q + 3'h1;
							seq_q  <= SBM_PICK;
						end
					end
					default: seq_q <= SBM_IDLE;
				endcase
				if (pass_end) begin
					slot_q <= 3'h0;
					if (mode_q[2]) begin
						seq_q <= SBM_PICK;
					end else begin
						seq_q <= SBM_IDLE;
						run_q <= 1'b0;
					end
				end
			end
		end
	end

	// Pass completion wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (srst)
			conversion_ready_flag_q <= 1'b0;
		else if (pass_end)
			conversion_ready_flag_q <= 1'b1;
		else if ((cfg_wr && pwdata[1:0] != 2'h0) || mask_rd)
			conversion_ready_flag_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Results, averaging and comparisons

	always_comb begin
		sum_d = 16'h0;
		for (int i = 0; i < 3; i++)
			if (scc_q[i])
				sum_d = sum_d + shunt_raw_q[i];
	end

	// Fewer than two selected channels turns the sum flag off
	assign sum_en = scc_q == 3'h3 || scc_q == 3'h5 || scc_q == 3'h6 ||
		scc_q == 3'h7;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cf_q <= 3'h0;
			eval_q <= 1'b0;
			eval_slot_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				shunt_raw_q[i] <= 16'h0;
				shunt_avg_q[i] <= 16'h0;
				bus_q[i]       <= 16'h0;
			end
		end else begin
			eval_q      <= res_stb;
			eval_slot_q <= conv_sel;
			if (res_stb && !conv_sel[0]) begin
				shunt_raw_q[conv_sel[2:1]] <= res_val;
				shunt_avg_q[conv_sel[2:1]] <= 16'(shunt_avg_q[conv_sel[2:1]]
					+ ((17'(res_val) - 17'(shunt_avg_q[conv_sel[2:1]]))
					>>> avg_shift(avg_q)));
				cf_q[conv_sel[2:1]] <= res_val >
					crit_lim_q[conv_sel[2:1]];
			end
			if (res_stb && conv_sel[0])
				bus_q[conv_sel[2:1]] <= res_val;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wf_q  <= 3'h0;
			sf_q  <= 1'b0;
			sum_q <= 16'h0;
		end else if (eval_q && !eval_slot_q[0]) begin
			wf_q[eval_slot_q[2:1]] <= shunt_avg_q[eval_slot_q[2:1]] >
				warn_lim_q[eval_slot_q[2:1]];
			sum_q <= sum_d;
			sf_q  <= sum_en && sum_d > sum_lim_q;
		end
	end

	// Hysteresis: rise needs all three at upper, fall needs one below lower
	always_ff @(posedge clk_sys) begin
		if (srst)
			pv_good_q <= 1'b0;
		else if (eval_q && eval_slot_q[0]) begin
			if (!pv_good_q && bus_q[0] >= pv_up_q && bus_q[1] >= pv_up_q &&
					bus_q[2] >= pv_up_q)
				pv_good_q <= 1'b1;
			else if (bus_q[0] < pv_lo_q || bus_q[1] < pv_lo_q ||
					bus_q[2] < pv_lo_q)
				pv_good_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-drain alert pads: enable high pulls the pad low

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			crit_o <= 1'b0;
			warn_o <= 1'b0;
			power_good_output_o <= 1'b0;
			sequence_timing_output_o <= 1'b0;
			crit_oe <= 1'b0;
			warn_oe <= 1'b0;
			power_good_output_oe <= 1'b1;
			sequence_timing_output_oe <= 1'b0;
		end else begin
			crit_oe <= |cf_q || sf_q;
			warn_oe <= |wf_q;
			power_good_output_oe <= !pv_good_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence s_single_start;
		cfg_wr && pwdata[1:0] != 2'h0;
	endsequence

	sequence s_single_end;
		pass_end && !mode_q[2] && !cfg_wr;
	endsequence

	chk_single_start: assert property (s_single_start ##1 slot_wanted(
		3'h0, mode_q, chen_q) |-> ##1 conv_req)
		else $error("no conversion after mode write");
	chk_single_stop: assert property (s_single_end |=>
		seq_q == SBM_IDLE && !run_q ##1 !conv_req)
		else $error("single pass did not stop");
	chk_ready_cause: assert property ($rose(conversion_ready_flag_q) |-> $past(pass_end))
		else $error("ready flag set without pass end");
	chk_ready_clear: assert property (mask_rd && !pass_end |=> !conversion_ready_flag_q)
		else $error("mask read left ready flag set");
	chk_crit_pad: assert property ($changed(cf_q) || $changed(sf_q)
		|=> crit_oe == (|$past(cf_q) || $past(sf_q)))
		else $error("critical pad does not follow flags");
	chk_warn_pad: assert property (eval_q ##1 (|wf_q) |=> warn_oe)
		else $error("warning pad not pulled");
	chk_pv_rise: assert property (eval_q && eval_slot_q[0] &&
		bus_q[0] >= pv_up_q && bus_q[1] >= pv_up_q && bus_q[2] >= pv_up_q
		|=> pv_good_q ##1 !power_good_output_oe)
		else $error("power-valid did not rise");
	chk_pv_fall: assert property (eval_q && eval_slot_q[0] &&
		bus_q[1] < pv_lo_q && bus_q[1] < pv_up_q |=> !pv_good_q[*2])
		else $error("power-valid did not fall");
	chk_lim_reset: assert property ($fell(srst) |->
		crit_lim_q[0] == `SBM_LIM_MAX && warn_lim_q[2] == `SBM_LIM_MAX)
		else $error("limit reset value wrong");

endmodule // sbm_monitor

/* File: test/sbm_conv_model.sv */
// Behavioural converter on the far side of the monitor's converter pins.
// Assumes one request at a time; the bench loads results by hierarchy.
`timescale 1ns/1ns
module sbm_conv_model (
	input  wire logic       clk_sys,   // System clock
	input  wire logic       conv_req,  // Start pulse
	input  wire logic [2:0] conv_sel,  // Slot of the conversion
	output logic            adc_sclk,  // Result bit clock
	output logic            adc_sdata, // Result bit
	output logic            adc_frame  // Result frame
);
	logic [12:0] res [0:5];
	int          cnt [0:5];
	int          gap_ns;
	logic [12:0] w;

	initial begin
		adc_sclk = 1'h0;
		adc_sdata = 1'h0;
		adc_frame = 1'h0;
		gap_ns = 200;
		for (int i = 0; i < 6; i++) begin
			res[i] = 13'h0000;
			cnt[i] = 0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One frame per request; clock stands still between frames and the
	// data line flips after release so a stale bit is never reread
	always begin
		// Mid-cycle look sees the one-cycle start pulse exactly once
		@(negedge clk_sys);
		if (conv_req === 1'h1) begin
			w = res[conv_sel];
			cnt[conv_sel]++;
			#(gap_ns);
			adc_frame = 1'h1;
			for (int b = 12; b >= 0; b--) begin
				adc_sdata = w[b];
				#160 adc_sclk = 1'h1;
				#160 adc_sclk = 1'h0;
			end
			#160 adc_frame = 1'h0;
			adc_sdata = ~adc_sdata;
		end
	end
endmodule // sbm_conv_model

/* File: test/tb_top.sv */
// Self-checking bench of the shunt and bus monitor alert block.
// Assumes the converter model stands on the converter pins.
`timescale 1ns/1ns
`include "sbm_regs.svh"
module tb_top;
	logic        clk_sys = 1'h0;
	logic        srst = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic [2:0]  conv_sel;
	logic        pready, pslverr, conv_req, adc_sclk, adc_sdata, adc_frame;
	logic        crit_o, crit_oe, warn_o, warn_oe, er;
	logic        power_good_output_o, power_good_output_oe;
	logic        sequence_timing_output_o, sequence_timing_output_oe;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;

	sbm_monitor u_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_req(conv_req), .conv_sel(conv_sel), .adc_sclk(adc_sclk),
		.adc_sdata(adc_sdata), .adc_frame(adc_frame), .crit_o(crit_o),
		.crit_oe(crit_oe), .warn_o(warn_o), .warn_oe(warn_oe),
		.power_good_output_o(power_good_output_o),
		.power_good_output_oe(power_good_output_oe),
		.sequence_timing_output_o(sequence_timing_output_o),
		.sequence_timing_output_oe(sequence_timing_output_oe));

	sbm_conv_model u_conv (.clk_sys(clk_sys), .conv_req(conv_req),
		.conv_sel(conv_sel), .adc_sclk(adc_sclk), .adc_sdata(adc_sdata),
		.adc_frame(adc_frame));

	always #20 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		logic rdy;
		rdy = 1'h0;
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		// Slave outputs are flops: the mid-cycle value is what the next
		// rising edge samples, and that edge completes the transfer
		for (int n = 0; n < 20 && rdy !== 1'h1; n++) begin
			@(negedge clk_sys);
			rdy = pready;
			rv = prdata;
			er = pslverr;
			@(posedge clk_sys);
		end
		psel <= 1'h0;
		penable <= 1'h0;
		if (rdy !== 1'h1) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, rdy, 1'h1);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rv, e);
	endtask

	task automatic wait_ready();
		for (int n = 0; n < 3000; n++) begin
			apb(1'h0, `SBM_OFF_MASK_EN, 32'h0);
			if (rv[8] === 1'h1)
				break;
		end
		chk(32'(rv[8]), 32'h1);
	endtask

	// Power down, let any frame in flight end, then start the mode
	task automatic shot(input logic [2:0] m, input logic [2:0] avg);
		apb(1'h1, `SBM_OFF_CONFIG, 32'h1c0);
		repeat (8) @(posedge clk_sys);
		for (int n = 0; n < 200 && adc_frame !== 1'h0; n++)
			@(posedge clk_sys);
		chk(32'(adc_frame), 32'h0);
		for (int s = 0; s < 6; s++)
			u_conv.cnt[s] = 0;
		apb(1'h1, `SBM_OFF_CONFIG, {23'h0, 3'h7, avg, m});
		wait_ready();
		repeat (4) @(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(32'(power_good_output_oe), 32'h1);
		rd(`SBM_OFF_CONFIG, 32'h1c7);
		rd(`SBM_OFF_CRIT1 + 8'h08, 32'h0fff);
		rd(`SBM_OFF_WARN1 + 8'h04, 32'h0fff);
		rd(`SBM_OFF_SUM_LIM, 32'h7fff);
		rd(`SBM_OFF_PV_UP, 32'h4e2);
		rd(`SBM_OFF_PV_LO, 32'h465);
		apb(1'h0, 8'h80, 32'h0);
		chk(32'(er), 32'h1);
	endtask

	task automatic t_modes();
		for (int s = 0; s < 6; s++)
			u_conv.res[s] = 13'(16 + s);
		for (int m = 1; m < 4; m++) begin
			shot(3'(m), 3'h0);
			for (int s = 0; s < 6; s++)
				chk(32'(u_conv.cnt[s]), 32'((s % 2) ? m / 2 : m % 2));
			repeat (300) @(posedge clk_sys);
			chk(32'(u_conv.cnt[5]), 32'(m / 2));
			apb(1'h0, `SBM_OFF_MASK_EN, 32'h0);
			chk(32'(rv[8]), 32'h0);
		end
		rd(`SBM_OFF_SHUNT1 + 8'h04, 32'h12);
		rd(`SBM_OFF_BUS1 + 8'h08, 32'h15);
		u_conv.res[0] = 13'h0050;
		shot(3'h1, 3'h1);
		rd(`SBM_OFF_SHUNT1, 32'h20);
	endtask

	task automatic t_crit();
		u_conv.res[0] = 13'h000a;
		u_conv.res[2] = 13'h012c;
		u_conv.res[4] = 13'h000a;
		apb(1'h1, `SBM_OFF_CRIT1 + 8'h04, 32'hc8);
		apb(1'h1, `SBM_OFF_WARN1 + 8'h04, 32'hfa);
		shot(3'h1, 3'h0);
		chk(32'(crit_oe), 32'h1);
		chk(32'(warn_oe), 32'h1);
		apb(1'h0, `SBM_OFF_MASK_EN, 32'h0);
		chk(rv & 32'h7f, 32'h22);
		apb(1'h1, `SBM_OFF_CRIT1 + 8'h04, 32'hfff);
		apb(1'h1, `SBM_OFF_WARN1 + 8'h04, 32'hfff);
		shot(3'h1, 3'h0);
		chk(32'({crit_oe, warn_oe}), 32'h0);
	endtask

	task automatic t_sum();
		for (int s = 0; s < 6; s += 2)
			u_conv.res[s] = 13'h0064;
		apb(1'h1, `SBM_OFF_SUM_LIM, 32'hfa);
		apb(1'h1, `SBM_OFF_MASK_EN, 32'h7000);
		shot(3'h1, 3'h0);
		chk(32'(crit_oe), 32'h1);
		rd(`SBM_OFF_SUM, 32'h12c);
		apb(1'h0, `SBM_OFF_MASK_EN, 32'h0);
		chk(rv & 32'h700f, 32'h7008);
		apb(1'h1, `SBM_OFF_SUM_LIM, 32'h96);
		apb(1'h1, `SBM_OFF_MASK_EN, 32'h3000);
		shot(3'h1, 3'h0);
		chk(32'(crit_oe), 32'h1);
		rd(`SBM_OFF_SUM, 32'hc8);
		apb(1'h1, `SBM_OFF_MASK_EN, 32'h1000);
		shot(3'h1, 3'h0);
		chk(32'(crit_oe), 32'h0);
	endtask

	task automatic t_pv();
		logic [12:0] v [0:5];
		logic        e [0:5];
		v = '{13'h04e1, 13'h04e2, 13'h0465, 13'h0464, 13'h04b0, 13'h04e2};
		e = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
		u_conv.res[1] = 13'h04e2;
		u_conv.res[5] = 13'h04e2;
		for (int i = 0; i < 6; i++) begin
			u_conv.res[3] = v[i];
			shot(3'h2, 3'h0);
			chk(32'(power_good_output_oe), 32'(e[i]));
		end
		chk(32'({crit_o, warn_o, power_good_output_o,
			sequence_timing_output_o, sequence_timing_output_oe}),
			32'h0);
	endtask

	task automatic t_cont();
		int c0;
		u_conv.gap_ns = 3000;
		shot(3'h7, 3'h0);
		wait_ready();
		chk(32'(u_conv.cnt[5] >= 2), 32'h1);
		apb(1'h1, `SBM_OFF_CONFIG, 32'h1c0);
		c0 = u_conv.cnt[0] + u_conv.cnt[5];
		repeat (600) @(posedge clk_sys);
		chk(32'(u_conv.cnt[0] + u_conv.cnt[5]), 32'(c0));
		u_conv.gap_ns = 200;
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'h0;
		@(posedge clk_sys);
		t_reset();
		t_modes();
		t_crit();
		t_sum();
		t_pv();
		t_cont();
		final_report();
	end
endmodule // tb_top
